// File: include/dbg_pkg.sv
// Package for the core debug unit: JTAG command codes, trigger layout,
// trace record layout, reset values and the software register map.
// Assumes a single clk_sys domain; JTAG pins are sampled, not clocked.
package dbg_pkg;

  // Widths fixed to the core buses
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int NUM_TRIG = 4;
  localparam int TRACE_DEPTH = 16;
  localparam int TRACE_IDX_W = 4;

  // JTAG data register: 4-bit command, 8-bit target, 32-bit value
  localparam int JCMD_W = 4;
  localparam int JTGT_W = 8;
  localparam int JSHIFT_W = 44;
  localparam int JVAL_LSB = 0;
  localparam int JTGT_LSB = 32;
  localparam int JCMD_LSB = 40;

  // JTAG commands carried in the command field
  localparam logic [3:0] JC_NOP = 4'h0;
  localparam logic [3:0] JC_HALT = 4'h1;
  localparam logic [3:0] JC_RESUME = 4'h2;
  localparam logic [3:0] JC_REG_RD = 4'h3;
  localparam logic [3:0] JC_REG_WR = 4'h4;
  localparam logic [3:0] JC_MEM_RD = 4'h5;
  localparam logic [3:0] JC_MEM_WR = 4'h6;
  localparam logic [3:0] JC_SET_ADDR = 4'h7;
  localparam logic [3:0] JC_TRACE_ON = 4'h8;
  localparam logic [3:0] JC_TRACE_OFF = 4'h9;
  localparam logic [3:0] JC_TRACE_RD = 4'hA;
  localparam logic [3:0] JC_TRIG_WR = 4'hB;
  localparam logic [3:0] JC_CFG_WR = 4'hC;
  localparam logic [3:0] JC_STATUS_RD = 4'hD;

  // Trigger setup fields written by JC_TRIG_WR, target = trig*4 + field
  localparam logic [1:0] TF_CTRL = 2'h0;
  localparam logic [1:0] TF_ADDR = 2'h1;
  localparam logic [1:0] TF_DATA = 2'h2;
  localparam logic [1:0] TF_ACT = 2'h3;

  // Trigger control bits
  localparam int TC_EN = 0;
  localparam int TC_IBUS = 1;
  localparam int TC_ADDR = 2;
  localparam int TC_DATA = 3;
  localparam int TC_RD = 4;
  localparam int TC_WR = 5;
  localparam int TC_ARMED = 6;
  localparam int TC_RANGE = 7;
  localparam int TC_W = 8;

  // Action bits
  localparam int TA_BREAK = 0;
  localparam int TA_EXT = 1;
  localparam int TA_TON = 2;
  localparam int TA_TOFF = 3;
  localparam int TA_SAMPLE = 4;
  localparam int TA_ARM = 5;
  localparam int TA_W = 6;

  // Trace configuration bits
  localparam int CF_ITRACE = 0;
  localparam int CF_DADDR = 1;
  localparam int CF_DDATA = 2;
  localparam int CF_STOP_FULL = 3;
  localparam int CF_LOADS = 4;
  localparam int CF_STORES = 5;
  localparam int CF_W = 6;
  localparam logic [5:0] CF_RESET = 6'h37;

  // Trace record kinds
  localparam logic [1:0] TK_INSTR = 2'h1;
  localparam logic [1:0] TK_DATA = 2'h2;

  // Register bus map (word offsets as byte addresses)
  localparam logic [7:0] RA_STATUS = 8'h00;
  localparam logic [7:0] RA_TRACE_CNT = 8'h04;
  localparam logic [7:0] RA_CTRL = 8'h08;
  localparam int RB_HALT = 0;
  localparam int RB_RESUME = 1;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } ibus_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dbus_s;

  typedef struct packed {
    logic [1:0] kind;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } trace_rec_s;

  typedef struct packed {
    logic [TC_W-1:0] ctrl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [TA_W-1:0] act;
  } trig_cfg_s;

  typedef enum logic [1:0] {ST_RUN, ST_HALT_REQ, ST_HALTED} run_e;

endpackage : dbg_pkg

// File: verilog/dbg_unit.sv
// Core debug unit: JTAG command port, run control, hardware triggers,
// trace capture into an on-chip buffer and an external probe stream.
// Assumes JTAG pins asynchronous to clk_sys (tck far slower), and a core
// that honours break_req, reports break opcodes and serves debug access.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module dbg_unit (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms_shift,
  input wire logic tms_update,
  input wire logic tdi,
  output logic tdo,
  input wire dbg_pkg::ibus_s ibus,
  input wire dbg_pkg::dbus_s dbus,
  input wire logic break_op,
  output logic break_req,
  output logic resume_req,
  output logic [31:0] resume_pc,
  output logic resume_pc_valid,
  input wire logic core_halted,
  output logic dbg_acc_req,
  output logic dbg_acc_mem,
  output logic dbg_acc_wr,
  output logic dbg_acc_super,
  output logic [31:0] dbg_acc_addr,
  output logic [31:0] dbg_acc_wdata,
  input wire logic dbg_acc_ack,
  input wire logic [31:0] dbg_acc_rdata,
  output logic ext_trig,
  output logic probe_valid,
  output dbg_pkg::trace_rec_s probe_rec,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // JTAG pin synchronisers, first stage read only by the second
  logic [3:0] jsync1_q, jsync2_q;
  logic tck_prev_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jsync1_q <= 4'h0;
      jsync2_q <= 4'h0;
      tck_prev_q <= 1'b0;
    end else begin
      jsync1_q <= {tck, tms_shift, tms_update, tdi};
      jsync2_q <= jsync1_q;
      tck_prev_q <= jsync2_q[3];
    end
  end
  logic tck_rise;
  assign tck_rise = jsync2_q[3] & ~tck_prev_q;

  // Shift register: in on tdi, out on tdo, LSB first
  logic [dbg_pkg::JSHIFT_W-1:0] jshift_q;
  logic [31:0] jresp_q;
  logic jresp_load_q;
  logic jcmd_go;
  assign jcmd_go = tck_rise & jsync2_q[1];
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jshift_q <= '0;
      tdo <= 1'b0;
    end else if (tck_rise & jsync2_q[2]) begin
      jshift_q <= {jsync2_q[0], jshift_q[dbg_pkg::JSHIFT_W-1:1]};
      tdo <= jshift_q[1];
    end else if (jresp_load_q) begin
      // Response replaces the value field for the next scan
      jshift_q <= {12'h000, jresp_q};
      tdo <= jresp_q[0];
    end
  end

  logic [3:0] jcmd;
  logic [7:0] jtgt;
  logic [31:0] jval;
  assign jcmd = jshift_q[dbg_pkg::JCMD_LSB +: dbg_pkg::JCMD_W];
  assign jtgt = jshift_q[dbg_pkg::JTGT_LSB +: dbg_pkg::JTGT_W];
  assign jval = jshift_q[dbg_pkg::JVAL_LSB +: 32];

  // Trigger configuration, written only over JTAG
  dbg_pkg::trig_cfg_s trig_q [dbg_pkg::NUM_TRIG];
  logic [dbg_pkg::CF_W-1:0] cfg_q;
  logic [31:0] acc_addr_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < dbg_pkg::NUM_TRIG; i++) begin
        trig_q[i] <= '0;
      end
      cfg_q <= dbg_pkg::CF_RESET;
      acc_addr_q <= 32'h0000_0000;
    end else if (jcmd_go) begin
      case (jcmd)
        dbg_pkg::JC_TRIG_WR: begin
          case (jtgt[1:0])
            dbg_pkg::TF_CTRL: trig_q[jtgt[3:2]].ctrl <= jval[dbg_pkg::TC_W-1:0];
            dbg_pkg::TF_ADDR: trig_q[jtgt[3:2]].addr <= jval;
            dbg_pkg::TF_DATA: trig_q[jtgt[3:2]].data <= jval;
            default: trig_q[jtgt[3:2]].act <= jval[dbg_pkg::TA_W-1:0];
          endcase
        end
        dbg_pkg::JC_CFG_WR: cfg_q <= jval[dbg_pkg::CF_W-1:0];
        dbg_pkg::JC_SET_ADDR: acc_addr_q <= jval;
        default: ;
      endcase
    end
  end

  // Per-trigger comparators, evaluated every transfer cycle
  logic [dbg_pkg::NUM_TRIG-1:0] cond_hit, hit, armed_q;
  logic [dbg_pkg::NUM_TRIG-1:0] act_brk, act_ext, act_ton, act_toff, act_smp, act_arm;
  genvar g;
  generate
    for (g = 0; g < dbg_pkg::NUM_TRIG; g++) begin : gen_trig
      dbg_pkg::trig_cfg_s c, hi;
      logic on_i, pres, a_ok, d_ok, r_ok, w_ok, rng_a, rng_d;
      assign c = trig_q[g];
      assign hi = trig_q[(g + 1) % dbg_pkg::NUM_TRIG];
      assign on_i = c.ctrl[dbg_pkg::TC_IBUS];
      assign pres = on_i ? ibus.valid : dbus.valid;
      // range uses next trigger as upper bound
      assign rng_a = (dbus.addr >= c.addr) && (dbus.addr <= hi.addr);
      assign rng_d = (dbus.data >= c.data) && (dbus.data <= hi.data);
      assign a_ok = !c.ctrl[dbg_pkg::TC_ADDR] ||
        (on_i ? (ibus.addr == c.addr) :
         (c.ctrl[dbg_pkg::TC_RANGE] ? rng_a : (dbus.addr == c.addr)));
      assign d_ok = !c.ctrl[dbg_pkg::TC_DATA] ||
        (!on_i && (c.ctrl[dbg_pkg::TC_RANGE] ? rng_d : (dbus.data == c.data)));
      assign r_ok = !c.ctrl[dbg_pkg::TC_RD] || (!on_i && !dbus.write);
      assign w_ok = !c.ctrl[dbg_pkg::TC_WR] || (!on_i && dbus.write);
      assign cond_hit[g] = c.ctrl[dbg_pkg::TC_EN] & pres & a_ok & d_ok & r_ok & w_ok;
      assign hit[g] = cond_hit[g] & (!c.ctrl[dbg_pkg::TC_ARMED] | armed_q[g]);
      assign act_brk[g] = hit[g] & c.act[dbg_pkg::TA_BREAK];
      assign act_ext[g] = hit[g] & c.act[dbg_pkg::TA_EXT];
      assign act_ton[g] = hit[g] & c.act[dbg_pkg::TA_TON];
      assign act_toff[g] = hit[g] & c.act[dbg_pkg::TA_TOFF];
      assign act_smp[g] = hit[g] & c.act[dbg_pkg::TA_SAMPLE] & !on_i;
      assign act_arm[g] = hit[g] & c.act[dbg_pkg::TA_ARM];
    end
  endgenerate

  // arm action enables every armed trigger; cleared when reconfigured
  // Arming wins a tie with a setup write so a live arm event is never lost
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      armed_q <= '0;
    end else if (|act_arm) begin
      armed_q <= armed_q | {dbg_pkg::NUM_TRIG{1'b1}};
    end else if (jcmd_go && jcmd == dbg_pkg::JC_TRIG_WR) begin
      armed_q <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_trig <= 1'b0;
    end else begin
      ext_trig <= |act_ext;
    end
  end

  // Run control state
  dbg_pkg::run_e run_q;
  logic host_halt, host_resume, sw_halt, sw_resume;
  assign host_halt = jcmd_go && jcmd == dbg_pkg::JC_HALT;
  assign host_resume = jcmd_go && jcmd == dbg_pkg::JC_RESUME;
  assign sw_halt = reg_wr && reg_addr == dbg_pkg::RA_CTRL && reg_wdata[dbg_pkg::RB_HALT];
  assign sw_resume = reg_wr && reg_addr == dbg_pkg::RA_CTRL && reg_wdata[dbg_pkg::RB_RESUME];
  // break request drives the core to its break handler
  // break opcode enters debug; fetch breakpoint via triggers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_q <= dbg_pkg::ST_RUN;
      break_req <= 1'b0;
      resume_req <= 1'b0;
      resume_pc <= 32'h0000_0000;
      resume_pc_valid <= 1'b0;
    end else begin
      resume_req <= 1'b0;
      case (run_q)
        dbg_pkg::ST_RUN: begin
          if (break_op) begin
            run_q <= dbg_pkg::ST_HALTED;
          end else if (host_halt | sw_halt | (|act_brk)) begin
            run_q <= dbg_pkg::ST_HALT_REQ;
            break_req <= 1'b1;
          end
        end
        dbg_pkg::ST_HALT_REQ: begin
          if (core_halted | break_op) begin
            run_q <= dbg_pkg::ST_HALTED;
            break_req <= 1'b0;
          end
        end
        dbg_pkg::ST_HALTED: begin
          // host or register resume; optional entry point in value, host resume only
          if (host_resume | sw_resume) begin
            run_q <= dbg_pkg::ST_RUN;
            resume_req <= 1'b1;
            resume_pc <= jval;
            resume_pc_valid <= host_resume & jtgt[0];
          end
        end
        default: run_q <= dbg_pkg::ST_RUN;
      endcase
    end
  end

  // Debug register and memory access, held until core acknowledges
  // supervisor privilege on every access
  // read and write of registers and memory
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dbg_acc_req <= 1'b0;
      dbg_acc_mem <= 1'b0;
      dbg_acc_wr <= 1'b0;
      dbg_acc_super <= 1'b1;
      dbg_acc_addr <= 32'h0000_0000;
      dbg_acc_wdata <= 32'h0000_0000;
    end else if (dbg_acc_req) begin
      if (dbg_acc_ack) begin
        dbg_acc_req <= 1'b0;
      end
    end else if (jcmd_go && (jcmd == dbg_pkg::JC_REG_RD || jcmd == dbg_pkg::JC_REG_WR ||
                 jcmd == dbg_pkg::JC_MEM_RD || jcmd == dbg_pkg::JC_MEM_WR)) begin
      dbg_acc_req <= 1'b1;
      dbg_acc_mem <= jcmd == dbg_pkg::JC_MEM_RD || jcmd == dbg_pkg::JC_MEM_WR;
      dbg_acc_wr <= jcmd == dbg_pkg::JC_REG_WR || jcmd == dbg_pkg::JC_MEM_WR;
      dbg_acc_super <= 1'b1;
      dbg_acc_addr <= (jcmd == dbg_pkg::JC_MEM_RD || jcmd == dbg_pkg::JC_MEM_WR) ?
                      acc_addr_q : {24'h00_0000, jtgt};
      dbg_acc_wdata <= jval;
    end
  end

  // Trace enable: host command beats trigger actions in the same cycle
  logic trace_on_q, full;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trace_on_q <= 1'b0;
    end else if (jcmd_go && jcmd == dbg_pkg::JC_TRACE_ON) begin
      trace_on_q <= 1'b1;
    end else if (jcmd_go && jcmd == dbg_pkg::JC_TRACE_OFF) begin
      trace_on_q <= 1'b0;
    end else if (full && cfg_q[dbg_pkg::CF_STOP_FULL]) begin
      // stop on full, core not halted
      trace_on_q <= 1'b0;
    end else if (|act_toff) begin
      trace_on_q <= 1'b0;
    end else if (|act_ton) begin
      trace_on_q <= 1'b1;
    end
  end

  // Record selection: data frames take priority over instruction here
  // since data trace must not drop any access; fetch frames may slip.
  logic d_take, i_take, rec_v;
  dbg_pkg::trace_rec_s rec;
  always_comb begin
    // bus choice and address/data fields per configuration
    d_take = dbus.valid && ((trace_on_q && (cfg_q[dbg_pkg::CF_DADDR] | cfg_q[dbg_pkg::CF_DDATA])
             && (dbus.write ? cfg_q[dbg_pkg::CF_STORES] : cfg_q[dbg_pkg::CF_LOADS]))
             || (|act_smp));
    i_take = trace_on_q && ibus.valid && cfg_q[dbg_pkg::CF_ITRACE];
    rec = '0;
    if (d_take) begin
      rec.kind = dbg_pkg::TK_DATA;
      rec.write = dbus.write;
      rec.addr = (cfg_q[dbg_pkg::CF_DADDR] | (|act_smp)) ? dbus.addr : 32'h0000_0000;
      rec.data = (cfg_q[dbg_pkg::CF_DDATA] | (|act_smp)) ? dbus.data : 32'h0000_0000;
    end else if (i_take) begin
      rec.kind = dbg_pkg::TK_INSTR;
      rec.addr = ibus.addr;
    end
    rec_v = d_take | i_take;
  end

  dbg_pkg::trace_rec_s tbuf_q [dbg_pkg::TRACE_DEPTH];
  logic [dbg_pkg::TRACE_IDX_W:0] tcnt_q;
  logic [dbg_pkg::TRACE_IDX_W-1:0] twr_q;
  assign full = tcnt_q[dbg_pkg::TRACE_IDX_W];
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tcnt_q <= '0;
      twr_q <= '0;
    end else if (jcmd_go && jcmd == dbg_pkg::JC_TRACE_ON) begin
      tcnt_q <= '0;
      twr_q <= '0;
    end else if (rec_v && !(full && cfg_q[dbg_pkg::CF_STOP_FULL])) begin
      tbuf_q[twr_q] <= rec;
      twr_q <= twr_q + 1'b1;
      if (!full) begin
        tcnt_q <= tcnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      probe_valid <= 1'b0;
      probe_rec <= '0;
    end else begin
      probe_valid <= rec_v;
      probe_rec <= rec;
    end
  end

  // JTAG responses, loaded after the command completes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jresp_q <= 32'h0000_0000;
      jresp_load_q <= 1'b0;
    end else begin
      jresp_load_q <= 1'b0;
      if (dbg_acc_req && dbg_acc_ack && !dbg_acc_wr) begin
        jresp_q <= dbg_acc_rdata;
        jresp_load_q <= 1'b1;
      end else if (jcmd_go && jcmd == dbg_pkg::JC_TRACE_RD) begin
        // Word select: target bit 4 kind word, bit 5 data, else address
        jresp_q <= jtgt[4] ? {29'h0000_0000, tbuf_q[jtgt[3:0]].write,
                   tbuf_q[jtgt[3:0]].kind} :
                   (jtgt[5] ? tbuf_q[jtgt[3:0]].data : tbuf_q[jtgt[3:0]].addr);
        jresp_load_q <= 1'b1;
      end else if (jcmd_go && jcmd == dbg_pkg::JC_STATUS_RD) begin
        jresp_q <= {24'h00_0000, 1'b0, armed_q[0], trace_on_q, tcnt_q};
        jresp_load_q <= 1'b1;
      end
    end
  end

  // Software register port: status and count only, no trace contents
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        dbg_pkg::RA_STATUS: reg_rdata <= {28'h000_0000, full, trace_on_q,
                                          run_q == dbg_pkg::ST_HALTED, break_req};
        dbg_pkg::RA_TRACE_CNT: reg_rdata <= {27'h000_0000, tcnt_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : dbg_unit

// File: sim/dbg_unit_props.sv
// Checker for dbg_unit: run control, debug access, triggers, trace stream.
// Assumes one clk_sys domain with synchronous active-high reset.
`timescale 1ns/1ps
module dbg_unit_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire dbg_pkg::ibus_s ibus,
  input wire dbg_pkg::dbus_s dbus,
  input wire logic break_op,
  input wire logic break_req,
  input wire logic core_halted,
  input wire logic resume_req,
  input wire logic dbg_acc_req,
  input wire logic dbg_acc_ack,
  input wire logic dbg_acc_super,
  input wire logic dbg_acc_wr,
  input wire logic [31:0] dbg_acc_addr,
  input wire logic ext_trig,
  input wire logic probe_valid,
  input wire dbg_pkg::trace_rec_s probe_rec,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Halt asked for, core not yet stopped
  sequence halt_wait;
    break_req && !core_halted && !break_op;
  endsequence
  // Access posted, no acknowledge yet
  sequence acc_wait;
    dbg_acc_req && !dbg_acc_ack;
  endsequence
  brk_hold_a: assert property (halt_wait |=> break_req)
    else $error("halt request dropped early");
  brk_done_a: assert property (break_op |=> !break_req)
    else $error("halt request kept after break opcode");
  acc_hold_a: assert property (acc_wait |=> dbg_acc_req && $stable(dbg_acc_addr)
    && $stable(dbg_acc_wr)) else $error("debug access changed before acknowledge");
  acc_super_a: assert property (dbg_acc_req |-> dbg_acc_super)
    else $error("debug access without supervisor level");
  res_pulse_a: assert property (resume_req |=> !resume_req)
    else $error("resume request longer than one cycle");
  ext_cause_a: assert property (ext_trig |-> $past(ibus.valid) || $past(dbus.valid))
    else $error("external trigger without bus transfer");
  rec_cause_a: assert property (probe_valid |-> $past(ibus.valid) || $past(dbus.valid))
    else $error("trace record without bus transfer");
  rec_addr_a: assert property (probe_valid && probe_rec.kind == dbg_pkg::TK_DATA
    |-> probe_rec.addr == $past(dbus.addr)) else $error("data record address wrong");
  stat_brk_a: assert property (reg_rd && reg_addr == dbg_pkg::RA_STATUS
    |=> reg_rdata[0] == $past(break_req)) else $error("status request bit wrong");
endmodule : dbg_unit_props

// File: sim/jtag_host.sv
// Host probe model: scans 44-bit command words LSB first over the pins.
// Assumes the unit samples tck with clk_sys; tck idles low between frames.
`timescale 1ns/1ps
module jtag_host (
  output logic tck,
  output logic tms_shift,
  output logic tms_update,
  output logic tdi,
  input wire logic tdo
);
  // Idle pins at time zero
  initial begin
    tck = 1'h0;
    tms_shift = 1'h0;
    tms_update = 1'h0;
    tdi = 1'h0;
  end
  // host command frame
  // The answer of the previous command comes back in r, tdo read before each rise
  task automatic scan(input logic [3:0] c, input logic [7:0] t, input logic [31:0] v,
      output logic [31:0] r);
    logic [43:0] w;
    logic [43:0] s;
    w = {c, t, v};
    #13 tms_shift = 1'h1;
    for (int i = 0; i < 44; i++) begin
      tdi = w[i];
      #100 s[i] = tdo;
      tck = 1'h1;
      #200 tck = 1'h0;
      #100;
    end
    tms_shift = 1'h0;
    tms_update = 1'h1;
    #100 tck = 1'h1;
    #200 tck = 1'h0;
    #100 tms_update = 1'h0;
    // Released data line flips so a stale level is never trusted
    tdi = ~tdi;
    #1200 r = s[31:0];
  endtask : scan
endmodule : jtag_host

// File: sim/dbg_unit_tb.sv
// Self-checking bench for dbg_unit: core stand-in, register port, host.
// Assumes jtag_host on the pins and the checker bound at the foot.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module dbg_unit_tb;
  localparam logic [31:0] MK = 32'h5A5A_0000;
  localparam logic [31:0] TA = 32'h0000_0100;
  localparam logic [31:0] DV = 32'h1234_5678;
  localparam logic [31:0] BP = 32'h0000_0400;
  // Condition table: ctrl, write, address, data matches, hit expected
  localparam logic [42:0] ROWS [14] = '{
    {8'h05, 1'h0, 32'h100, 1'h1, 1'h1}, {8'h05, 1'h0, 32'h104, 1'h1, 1'h0},
    {8'h09, 1'h0, 32'h200, 1'h1, 1'h1}, {8'h09, 1'h0, 32'h100, 1'h0, 1'h0},
    {8'h11, 1'h0, 32'h300, 1'h0, 1'h1}, {8'h11, 1'h1, 32'h300, 1'h0, 1'h0},
    {8'h21, 1'h1, 32'h300, 1'h0, 1'h1}, {8'h21, 1'h0, 32'h300, 1'h0, 1'h0},
    {8'h25, 1'h0, 32'h100, 1'h0, 1'h0}, {8'h25, 1'h1, 32'h100, 1'h0, 1'h1},
    {8'h25, 1'h1, 32'h104, 1'h0, 1'h0}, {8'h85, 1'h0, 32'h180, 1'h0, 1'h1},
    {8'h85, 1'h1, 32'h1FF, 1'h0, 1'h1}, {8'h85, 1'h0, 32'h200, 1'h0, 1'h0}};
  logic clk_sys, reset, tck, tms_shift, tms_update, tdi, tdo, break_op, break_req;
  logic resume_req, resume_pc_valid, core_halted, dbg_acc_req, dbg_acc_mem, dbg_acc_wr;
  logic dbg_acc_super, dbg_acc_ack, ext_trig, probe_valid, reg_wr, reg_rd, w, m, e, x, b;
  logic [7:0] reg_addr, c;
  logic [31:0] resume_pc, dbg_acc_addr, dbg_acc_wdata, dbg_acc_rdata, reg_wdata;
  logic [31:0] reg_rdata, a, d, r;
  dbg_pkg::ibus_s ibus;
  dbg_pkg::dbus_s dbus;
  dbg_pkg::trace_rec_s probe_rec, last_rec;
  int fail_count = 0, tests_run = 0, cyc = 0, probes = 0, n;
  dbg_unit dbg_unit_inst (.clk_sys, .reset, .tck, .tms_shift, .tms_update, .tdi, .tdo,
    .ibus, .dbus, .break_op, .break_req, .resume_req, .resume_pc, .resume_pc_valid,
    .core_halted, .dbg_acc_req, .dbg_acc_mem, .dbg_acc_wr, .dbg_acc_super, .dbg_acc_addr,
    .dbg_acc_wdata, .dbg_acc_ack, .dbg_acc_rdata, .ext_trig, .probe_valid, .probe_rec,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  jtag_host jtag_host_inst (.tck, .tms_shift, .tms_update, .tdi, .tdo);
  // 20 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Core stand-in: stops on request or opcode, answers access next cycle
  always @(posedge clk_sys) begin
    core_halted <= reset ? 1'h0 : (break_req | break_op | core_halted) & ~resume_req;
    dbg_acc_ack <= !reset && dbg_acc_req && !dbg_acc_ack;
    dbg_acc_rdata <= reset ? '0 : dbg_acc_req & ~dbg_acc_ack ? dbg_acc_addr ^ MK : ~dbg_acc_rdata;
    cyc <= cyc + 1;
    if (probe_valid) begin
      probes <= probes + 1;
      last_rec <= probe_rec;
    end
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] ad, input logic [31:0] q);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= q;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask : wr
  // One bus transfer; released bus shows inverted values
  task automatic beat(input logic i, input logic wi, input logic [31:0] ai,
      input logic [31:0] di, output logic xo, output logic bo);
    @(posedge clk_sys);
    if (i) ibus <= '{1'h1, ai};
    else dbus <= '{1'h1, wi, ai, di};
    @(posedge clk_sys);
    ibus <= '{1'h0, ~ai};
    dbus <= '{1'h0, ~wi, ~ai, ~di};
    #1 xo = ext_trig;
    bo = break_req;
  endtask : beat
  task automatic jc(input logic [3:0] cm, input logic [7:0] t, input logic [31:0] v);
    jtag_host_inst.scan(cm, t, v, r);
  endtask : jc
  // Enable goes last so a half-set trigger never fires
  task automatic trig(input logic [1:0] k, input logic [7:0] ct, input logic [31:0] ad,
      input logic [5:0] act);
    jc(dbg_pkg::JC_TRIG_WR, {4'h0, k, dbg_pkg::TF_ADDR}, ad);
    jc(dbg_pkg::JC_TRIG_WR, {4'h0, k, dbg_pkg::TF_DATA}, DV);
    jc(dbg_pkg::JC_TRIG_WR, {4'h0, k, dbg_pkg::TF_ACT}, {26'h0, act});
    jc(dbg_pkg::JC_TRIG_WR, {4'h0, k, dbg_pkg::TF_CTRL}, {24'h0, ct});
  endtask : trig
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  // Main sequence
  initial begin
    reset = 1'h1;
    {break_op, reg_wr, reg_rd} = 3'h0;
    {reg_addr, reg_wdata, ibus, dbus} = '0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    settle();
    rd(dbg_pkg::RA_STATUS, d);
    `CHK("status reset", 32'h0, d)
    rd(8'h0C, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("supervisor", 1'h1, dbg_acc_super)
    wr(dbg_pkg::RA_CTRL, 32'h1);
    settle();
    rd(dbg_pkg::RA_STATUS, d);
    `CHK("reg halt", 4'h2, d[3:0])
    wr(dbg_pkg::RA_CTRL, 32'h2);
    settle();
    jc(dbg_pkg::JC_HALT, 8'h00, 32'h0);
    rd(dbg_pkg::RA_STATUS, d);
    `CHK("host halt", 4'h2, d[3:0])
    jc(dbg_pkg::JC_SET_ADDR, 8'h00, 32'h0000_1234);
    jc(dbg_pkg::JC_MEM_RD, 8'h00, 32'h0);
    jc(dbg_pkg::JC_REG_RD, 8'h05, 32'h0);
    `CHK("mem read", 32'h0000_1234 ^ MK, r)
    jc(dbg_pkg::JC_MEM_WR, 8'h00, 32'h0000_C0DE);
    `CHK("reg read", 32'h0000_0005 ^ MK, r)
    `CHK("mem write", {2'h3, 32'h0000_C0DE}, {dbg_acc_mem, dbg_acc_wr, dbg_acc_wdata})
    jc(dbg_pkg::JC_RESUME, 8'h01, 32'h0000_0200);
    `CHK("entry pc", {1'h1, 32'h0000_0200}, {resume_pc_valid, resume_pc})
    @(posedge clk_sys);
    break_op <= 1'h1;
    @(posedge clk_sys);
    break_op <= 1'h0;
    rd(dbg_pkg::RA_STATUS, d);
    `CHK("opcode halt", 4'h2, d[3:0])
    wr(dbg_pkg::RA_CTRL, 32'h2);
    trig(2'h0, 8'h07, BP, 6'h01);
    beat(1'h1, 1'h0, BP + 32'h4, DV, x, b);
    `CHK("no break", 1'h0, b)
    beat(1'h1, 1'h0, BP, DV, x, b);
    `CHK("fetch break", 1'h1, b)
    settle();
    wr(dbg_pkg::RA_CTRL, 32'h2);
    jc(dbg_pkg::JC_TRIG_WR, 8'h00, 32'h0);
    jc(dbg_pkg::JC_TRIG_WR, 8'h09, 32'h0000_01FF);
    trig(2'h1, 8'h00, TA, 6'h02);
    foreach (ROWS[k]) begin
      {c, w, a, m, e} = ROWS[k];
      jc(dbg_pkg::JC_TRIG_WR, 8'h04, {24'h0, c});
      beat(1'h0, w, a, m ? DV : ~DV, x, b);
      `CHK("condition", e, x)
    end
    jc(dbg_pkg::JC_TRIG_WR, 8'h04, 32'h0);
    trig(2'h2, 8'h61, TA, 6'h02);
    trig(2'h3, 8'h11, TA, 6'h20);
    beat(1'h0, 1'h1, TA, DV, x, b);
    `CHK("not armed", 1'h0, x)
    beat(1'h0, 1'h0, TA, DV, x, b);
    beat(1'h0, 1'h1, TA, DV, x, b);
    `CHK("armed hit", 1'h1, x)
    jc(dbg_pkg::JC_TRIG_WR, 8'h08, 32'h0);
    jc(dbg_pkg::JC_TRIG_WR, 8'h0C, 32'h0);
    jc(dbg_pkg::JC_TRACE_ON, 8'h00, 32'h0);
    n = probes;
    beat(1'h1, 1'h0, BP, DV, x, b);
    beat(1'h0, 1'h1, TA, DV, x, b);
    settle();
    `CHK("records", 2, probes - n)
    `CHK("data record", {dbg_pkg::TK_DATA, 1'h1, TA, DV}, last_rec)
    rd(dbg_pkg::RA_TRACE_CNT, d);
    `CHK("trace count", 5'h02, d[4:0])
    jc(dbg_pkg::JC_TRACE_RD, 8'h21, 32'h0);
    jc(dbg_pkg::JC_STATUS_RD, 8'h00, 32'h0);
    `CHK("buffer read", DV, r)
    jc(dbg_pkg::JC_TRACE_OFF, 8'h00, 32'h0);
    `CHK("status word", 32'h0000_0022, r)
    n = probes;
    beat(1'h0, 1'h1, TA, DV, x, b);
    settle();
    `CHK("host off", 0, probes - n)
    trig(2'h0, 8'h07, BP, 6'h04);
    trig(2'h1, 8'h07, BP + 32'h4, 6'h08);
    beat(1'h1, 1'h0, BP, DV, x, b);
    settle();
    n = probes;
    beat(1'h0, 1'h0, TA, DV, x, b);
    beat(1'h1, 1'h0, BP + 32'h4, DV, x, b);
    settle();
    `CHK("trigger on", 2, probes - n)
    n = probes;
    beat(1'h0, 1'h0, TA, DV, x, b);
    settle();
    `CHK("trigger off", 0, probes - n)
    jc(dbg_pkg::JC_TRIG_WR, 8'h03, 32'h10);
    jc(dbg_pkg::JC_TRIG_WR, 8'h07, 32'h10);
    jc(dbg_pkg::JC_TRIG_WR, 8'h04, 32'h05);
    n = probes;
    beat(1'h1, 1'h0, BP, DV, x, b);
    beat(1'h0, 1'h1, BP + 32'h4, DV, x, b);
    settle();
    `CHK("data sample only", 1, probes - n)
    `CHK("sample rec", {dbg_pkg::TK_DATA, 1'h1, BP + 32'h4, DV}, last_rec)
    jc(dbg_pkg::JC_TRIG_WR, 8'h00, 32'h0);
    jc(dbg_pkg::JC_TRIG_WR, 8'h04, 32'h0);
    jc(dbg_pkg::JC_CFG_WR, 8'h00, 32'h3F);
    jc(dbg_pkg::JC_TRACE_ON, 8'h00, 32'h0);
    n = probes;
    repeat (20) beat(1'h0, 1'h1, TA, DV, x, b);
    settle();
    `CHK("full stop", 16, probes - n)
    rd(dbg_pkg::RA_TRACE_CNT, d);
    `CHK("full count", 5'h10, d[4:0])
    rd(dbg_pkg::RA_STATUS, d);
    `CHK("full, running", 3'h4, {d[3], d[0], core_halted})
    give_verdict();
  end
endmodule : dbg_unit_tb
bind dbg_unit dbg_unit_props dbg_unit_props_inst (.clk_sys, .reset, .ibus, .dbus, .break_op,
  .break_req, .core_halted, .resume_req, .dbg_acc_req, .dbg_acc_ack, .dbg_acc_super,
  .dbg_acc_wr, .dbg_acc_addr, .ext_trig, .probe_valid, .probe_rec, .reg_addr, .reg_rd,
  .reg_rdata);
